// file: pkg/phasing_pkg.sv
// Shared constants, types and limit lookup for the payload phasing offset block
package phasing_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths of the signed offset fields, the combined shift, the write value and the register address
  localparam int CLK_W = 12;
  localparam int LINE_W = 11;
  localparam int FRAME_W = 6;
  localparam int TOTAL_W = 32;
  localparam int VALUE_W = 16;
  localparam int ADDR_W = 5;

  ////////////////////////////////////////////////////////////////////////////
  // Sub-27M counting rate and line periods
  localparam real SUB27_CLK_MHZ = 27.0;
  localparam real NTSC_LINE_US = 63.519;
  localparam real PAL_B_LINE_US = 63.963;
  // Longest clock offsets, rounded down to whole sub-27M clocks
  localparam logic [CLK_W-1:0] NTSC_CLK_MAX = CLK_W'($rtoi(NTSC_LINE_US * SUB27_CLK_MHZ));
  localparam logic [CLK_W-1:0] PAL_B_CLK_MAX = CLK_W'($rtoi(PAL_B_LINE_US * SUB27_CLK_MHZ));
  // Line and frame limits: 524 and 29 for NTSC/PAL-M, 624 and 24 for PAL-B
  localparam logic [LINE_W-1:0] NTSC_LINE_MAX = 11'h20c;
  localparam logic [LINE_W-1:0] PAL_B_LINE_MAX = 11'h270;
  localparam logic [FRAME_W-1:0] NTSC_FRAME_MAX = 6'h1d;
  localparam logic [FRAME_W-1:0] PAL_B_FRAME_MAX = 6'h18;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
  localparam logic [ADDR_W-1:0] REG_FORMAT = 5'h04;
  localparam logic [ADDR_W-1:0] REG_CLK_OFF = 5'h08;
  localparam logic [ADDR_W-1:0] REG_LINE_OFF = 5'h0c;
  localparam logic [ADDR_W-1:0] REG_FRAME_OFF = 5'h10;
  localparam logic [ADDR_W-1:0] REG_ADJUST = 5'h14;
  localparam logic [ADDR_W-1:0] REG_TOTAL = 5'h18;
  localparam logic [ADDR_W-1:0] REG_STATUS = 5'h1c;
  // Field positions
  localparam int CTRL_SEL_LSB = 0;
  localparam int CTRL_EN_BIT = 4;
  localparam int CTRL_STD_LSB = 8;
  localparam int ADJ_FIELD_LSB = 16;
  localparam int STAT_EN_BIT = 4;
  localparam int STAT_HD_BIT = 5;
  localparam int STAT_LIVE_BIT = 6;
  localparam logic [3:0] FULL_BE = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // Video standards; STD_HD stands for any high definition format
  typedef enum logic [1:0] {STD_NTSC, STD_PAL_B, STD_PAL_M, STD_HD} video_std_e;
  // Target field of an offset write
  typedef enum logic [1:0] {FIELD_CLOCK, FIELD_LINE, FIELD_FRAME} field_e;
  // One stored set of offsets
  typedef struct packed {
    logic signed [CLK_W-1:0] clk;
    logic signed [LINE_W-1:0] line;
    logic signed [FRAME_W-1:0] frame;
  } offset_s;
  // Positive limits of one standard
  typedef struct packed {
    logic [CLK_W-1:0] clk_max;
    logic [LINE_W-1:0] line_max;
    logic [FRAME_W-1:0] frame_max;
  } limits_s;
  // Reset values
  localparam video_std_e RST_STD = STD_NTSC;

  // Limits of a standard; PAL-M shares the NTSC figures
  function automatic limits_s std_limits(input video_std_e s);
    limits_s l;
    l = '{NTSC_CLK_MAX, NTSC_LINE_MAX, NTSC_FRAME_MAX};
    if (s == STD_PAL_B) begin
      l = '{PAL_B_CLK_MAX, PAL_B_LINE_MAX, PAL_B_FRAME_MAX};
    end
    return l;
  endfunction

endpackage

// file: verilog/offset_carry_chain.sv
// Wrap and carry chain across the clock, line and frame offset fields
`timescale 1ns/1ps
module offset_carry_chain (
  // Stored entry and the write applied to it
  input phasing_pkg::offset_s i_base,
  input phasing_pkg::field_e i_field,
  input logic i_add,
  input logic signed [phasing_pkg::VALUE_W-1:0] i_value,
  // Limits of the target standard
  input phasing_pkg::limits_s i_limits,
  // Wrapped entry
  output phasing_pkg::offset_s o_result
);

  localparam int SUM_W = phasing_pkg::VALUE_W + 1;
  typedef logic signed [SUM_W-1:0] sum_t;

  sum_t c_sum; // Clock field before wrap
  sum_t l_sum; // Line field before wrap, carry included
  sum_t f_sum; // Frame field before wrap, carry included
  logic signed [1:0] c_cy; // Carry out of the clock field
  logic signed [1:0] l_cy; // Carry out of the line field
  logic signed [1:0] f_cy; // Frame overflow, dropped at the end of the chain

  // Plus one above the limit, minus one below its negation
  function automatic logic signed [1:0] carry_of(input sum_t s, input logic [11:0] lim);
    sum_t top;
    top = sum_t'({1'b0, lim});
    if (s > top) begin
      carry_of = 2'sd1;
    end else if (s < -top) begin
      carry_of = -2'sd1;
    end else begin
      carry_of = 2'sd0;
    end
  endfunction

  // All three fields settle in one pass so no half-carried value is seen
  always_comb begin
    c_sum = sum_t'(i_base.clk);
    if (i_field == phasing_pkg::FIELD_CLOCK) begin
      c_sum = i_add ? c_sum + sum_t'(i_value) : sum_t'(i_value);
    end
    c_cy = carry_of(c_sum, i_limits.clk_max);
    l_sum = sum_t'(i_base.line);
    if (i_field == phasing_pkg::FIELD_LINE) begin
      l_sum = i_add ? l_sum + sum_t'(i_value) : sum_t'(i_value);
    end
    l_sum = l_sum + sum_t'(c_cy);
    l_cy = carry_of(l_sum, {1'b0, i_limits.line_max});
    f_sum = sum_t'(i_base.frame);
    if (i_field == phasing_pkg::FIELD_FRAME) begin
      f_sum = i_add ? f_sum + sum_t'(i_value) : sum_t'(i_value);
    end
    f_sum = f_sum + sum_t'(l_cy);
    f_cy = carry_of(f_sum, {6'h00, i_limits.frame_max});
    // A field past its limit returns to zero
    o_result.clk = (c_cy != 2'sd0) ? '0 : c_sum[phasing_pkg::CLK_W-1:0];
    o_result.line = (l_cy != 2'sd0) ? '0 : l_sum[phasing_pkg::LINE_W-1:0];
    o_result.frame = (f_cy != 2'sd0) ? '0 : f_sum[phasing_pkg::FRAME_W-1:0];
  end

endmodule

// file: verilog/phase_total_calc.sv
// Registered total phase shift of one output in sub-27M clocks
`timescale 1ns/1ps
module phase_total_calc (
  // Clock and reset
  input logic i_core_clk,
  input logic i_rst,
  // Active offsets and their standard
  input phasing_pkg::offset_s i_offset,
  input phasing_pkg::limits_s i_limits,
  input logic i_live,
  // Combined shift
  output logic signed [phasing_pkg::TOTAL_W-1:0] o_total,
  output logic o_live
);

  logic signed [phasing_pkg::TOTAL_W-1:0] line_clks; // Clocks in one line
  logic signed [phasing_pkg::TOTAL_W-1:0] frame_lines; // Lines in one frame
  logic signed [phasing_pkg::TOTAL_W-1:0] sum; // Combined shift

  // Frame and line offsets scaled to clocks, plus the clock offset
  always_comb begin
    line_clks = $signed({20'h00000, i_limits.clk_max}) + 32'sd1;
    frame_lines = $signed({21'h000000, i_limits.line_max}) + 32'sd1;
    sum = 32'(i_offset.frame) * frame_lines * line_clks;
    sum = sum + 32'(i_offset.line) * line_clks + 32'(i_offset.clk);
  end

  // An idle or high definition output carries no shift
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_total <= '0;
      o_live <= 1'b0;
    end else begin
      o_total <= i_live ? sum : '0;
      o_live <= i_live;
    end
  end

endmodule

// file: verilog/payload_phasing.sv
// Per-output time reference payload phasing offsets behind an Avalon-MM slave
//
// Operation
// - Separate offset sets per output and standard.
// - Format change reloads that output's stored offsets.
// - High definition output ignores and disables phasing.
// - Clock, line, frame combine into one shift.
// - Field past its maximum wraps, carries upward.
// - Clock offset counts sub-27M clock periods.
// - Clock overflow adds one line.
// - Clock underflow removes one line.
// - Line overflow adds one frame.
// - Line underflow removes one frame.
// - Frame field wraps with no further carry.
// - Limits follow NTSC, PAL-M or PAL-B figures.
//
// Our own choices: the address map and the Avalon-MM register port.
`timescale 1ns/1ps
module payload_phasing #(
  parameter int NUM_OUTPUTS = 4,
  parameter int SEL_W = 2
) (
  // Clock and reset
  input logic i_core_clk,
  input logic i_rst,
  // Avalon-MM register slave
  input logic [phasing_pkg::ADDR_W-1:0] i_avs_address,
  input logic i_avs_read,
  input logic i_avs_write,
  input logic [31:0] i_avs_writedata,
  input logic [3:0] i_avs_byteenable,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Per-output payload phasing
  output logic [NUM_OUTPUTS-1:0][phasing_pkg::TOTAL_W-1:0] o_payload_shift,
  output logic [NUM_OUTPUTS-1:0] o_shift_live,
  output logic [NUM_OUTPUTS-1:0] o_output_enable
);

  ////////////////////////////////////////////////////////////////////////////
  // Declarations

  // Number of standards that own a stored set
  localparam int NUM_STDS = 3;

  // Bus handshake
  logic req; // A read or write is pending
  logic ack; // Answer cycle of the pending request
  logic wr_fire; // Write takes effect at this edge
  logic rd_take; // Read data is captured at this edge
  logic [31:0] rd_mux; // Read data before its flop

  // Selection and configuration
  logic [SEL_W-1:0] video_output_select; // Output under edit
  phasing_pkg::video_std_e video_standard_select; // Standard under edit
  logic [NUM_OUTPUTS-1:0] video_output_enable; // Output enables
  phasing_pkg::video_std_e out_format [NUM_OUTPUTS]; // Format of each output

  // Offset storage: one set per output and per standard
  phasing_pkg::offset_s stored [NUM_OUTPUTS][NUM_STDS];
  // Offsets in use on each output
  phasing_pkg::offset_s active [NUM_OUTPUTS];

  // Write path into the carry chain
  phasing_pkg::offset_s edit_entry; // Entry addressed by the edit selection
  phasing_pkg::offset_s next_entry; // That entry after the write
  phasing_pkg::field_e wr_field; // Field the write targets
  logic wr_add; // Adjust adds to the field rather than set it
  logic is_off_addr; // Address is one of the offset registers
  logic sel_hd; // Selected output carries high definition
  logic edit_ok; // Edit standard owns a stored set
  logic off_wr; // Offset write accepted
  logic fmt_wr; // Format write accepted
  logic ctrl_wr; // Control write accepted
  phasing_pkg::video_std_e new_format; // Format being written
  logic [SEL_W-1:0] new_select; // Output select being written
  logic [NUM_OUTPUTS-1:0] live; // Output shows a phasing shift

  ////////////////////////////////////////////////////////////////////////////
  // Avalon-MM handshake

  // One wait cycle on every access keeps decode and read mux off the
  // same edge as the master's sample, at the cost of half the bus rate
  assign req = i_avs_read | i_avs_write;
  assign o_avs_waitrequest = req & ~ack;
  assign wr_fire = i_avs_write & ack & (i_avs_byteenable == phasing_pkg::FULL_BE);
  assign rd_take = i_avs_read & ~ack;

  // Answer flag rises one cycle after the request and drops after it
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      ack <= 1'b0;
    end else begin
      ack <= req & ~ack;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Write decode

  // Partial byte writes are dropped whole, as a field split over
  // two accesses could not be wrapped as one value
  always_comb begin
    is_off_addr = 1'b1;
    wr_add = 1'b0;
    wr_field = phasing_pkg::FIELD_CLOCK;
    case (i_avs_address)
      // Set the clock offset
      phasing_pkg::REG_CLK_OFF: begin
        wr_field = phasing_pkg::FIELD_CLOCK;
      end
      // Set the line offset
      phasing_pkg::REG_LINE_OFF: begin
        wr_field = phasing_pkg::FIELD_LINE;
      end
      // Set the frame offset
      phasing_pkg::REG_FRAME_OFF: begin
        wr_field = phasing_pkg::FIELD_FRAME;
      end
      // Step a chosen field by a signed amount
      phasing_pkg::REG_ADJUST: begin
        wr_field = phasing_pkg::field_e'(i_avs_writedata[phasing_pkg::ADJ_FIELD_LSB +: 2]);
        wr_add = 1'b1;
      end
      // Not an offset register
      default: begin
        is_off_addr = 1'b0;
      end
    endcase
  end

  // Gate offset writes on the selected output's state
  assign sel_hd = (out_format[video_output_select] == phasing_pkg::STD_HD);
  assign edit_ok = (video_standard_select != phasing_pkg::STD_HD);
  assign off_wr = wr_fire & is_off_addr & video_output_enable[video_output_select]
    & ~sel_hd & edit_ok;
  assign fmt_wr = wr_fire & (i_avs_address == phasing_pkg::REG_FORMAT);
  assign ctrl_wr = wr_fire & (i_avs_address == phasing_pkg::REG_CTRL);
  assign new_format = phasing_pkg::video_std_e'(i_avs_writedata[1:0]);
  assign new_select = i_avs_writedata[phasing_pkg::CTRL_SEL_LSB +: SEL_W];

  ////////////////////////////////////////////////////////////////////////////
  // Carry chain on the entry under edit

  // Entry of the selected output and edit standard; zero for no entry
  assign edit_entry = edit_ok ? stored[video_output_select][video_standard_select] : '0;

  // Wrap and carry across fields under the edit standard's limits
  offset_carry_chain u_chain (
    .i_base(edit_entry),
    .i_field(wr_field),
    .i_add(wr_add),
    .i_value(i_avs_writedata[phasing_pkg::VALUE_W-1:0]),
    .i_limits(phasing_pkg::std_limits(video_standard_select)),
    .o_result(next_entry)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Control registers

  // Output select, edit standard and per-output enable
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      video_output_select <= '0;
      video_standard_select <= phasing_pkg::RST_STD;
      video_output_enable <= '0;
    end else if (ctrl_wr) begin
      video_output_select <= new_select;
      video_standard_select <= phasing_pkg::video_std_e'(
        i_avs_writedata[phasing_pkg::CTRL_STD_LSB +: 2]);
      // Enable bit lands on the newly selected output
      video_output_enable[new_select] <= i_avs_writedata[phasing_pkg::CTRL_EN_BIT];
    end
  end

  // Video format of the selected output
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        out_format[i] <= phasing_pkg::RST_STD;
      end
    end else if (fmt_wr) begin
      out_format[video_output_select] <= new_format;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Offset storage

  // Only the entry for the selected output and edit standard changes;
  // the whole entry is written at once, carries included
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        for (int s = 0; s < NUM_STDS; s++) begin
          stored[i][s] <= '0;
        end
      end
    end else if (off_wr) begin
      stored[video_output_select][video_standard_select] <= next_entry;
    end
  end

  // Offsets in use: recalled on a format change, or followed live when
  // the edit standard is the one the output carries
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      for (int i = 0; i < NUM_OUTPUTS; i++) begin
        active[i] <= '0;
      end
    end else if (fmt_wr) begin
      if (new_format == phasing_pkg::STD_HD) begin
        active[video_output_select] <= '0;
      end else begin
        active[video_output_select] <= stored[video_output_select][new_format];
      end
    end else if (off_wr && (video_standard_select == out_format[video_output_select])) begin
      active[video_output_select] <= next_entry;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-output shift

  // One registered total per output, scaled by that output's standard
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
    assign live[g] = video_output_enable[g] & (out_format[g] != phasing_pkg::STD_HD);
    phase_total_calc u_total (
      .i_core_clk(i_core_clk),
      .i_rst(i_rst),
      .i_offset(active[g]),
      .i_limits(phasing_pkg::std_limits(out_format[g])),
      .i_live(live[g]),
      .o_total(o_payload_shift[g]),
      .o_live(o_shift_live[g])
    );
  end

  // Enables go out straight from their register
  assign o_output_enable = video_output_enable;

  ////////////////////////////////////////////////////////////////////////////
  // Read path

  // Register contents as seen for the selected output
  always_comb begin
    rd_mux = '0;
    case (i_avs_address)
      // Selection and enable
      phasing_pkg::REG_CTRL: begin
        rd_mux[phasing_pkg::CTRL_SEL_LSB +: SEL_W] = video_output_select;
        rd_mux[phasing_pkg::CTRL_EN_BIT] = video_output_enable[video_output_select];
        rd_mux[phasing_pkg::CTRL_STD_LSB +: 2] = video_standard_select;
      end
      // Format of the selected output
      phasing_pkg::REG_FORMAT: begin
        rd_mux[1:0] = out_format[video_output_select];
      end
      // Stored offsets, sign extended
      phasing_pkg::REG_CLK_OFF: begin
        rd_mux = 32'(edit_entry.clk);
      end
      phasing_pkg::REG_LINE_OFF: begin
        rd_mux = 32'(edit_entry.line);
      end
      phasing_pkg::REG_FRAME_OFF: begin
        rd_mux = 32'(edit_entry.frame);
      end
      // Combined shift now on the selected output
      phasing_pkg::REG_TOTAL: begin
        rd_mux = o_payload_shift[video_output_select];
      end
      // Live state of the selected output
      phasing_pkg::REG_STATUS: begin
        rd_mux[1:0] = out_format[video_output_select];
        rd_mux[phasing_pkg::STAT_EN_BIT] = video_output_enable[video_output_select];
        rd_mux[phasing_pkg::STAT_HD_BIT] = sel_hd;
        rd_mux[phasing_pkg::STAT_LIVE_BIT] = o_shift_live[video_output_select];
      end
      // Adjust is write-only; unmapped reads return zero
      default: begin
        rd_mux = '0;
      end
    endcase
  end

  // Read data is caught in the wait cycle and stands through the answer
  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      o_avs_readdata <= '0;
    end else if (rd_take) begin
      o_avs_readdata <= rd_mux;
    end
  end

endmodule

// file: dv/payload_phasing_chk.sv
// Port-level assertions for the payload phasing block
`timescale 1ns/1ps
module payload_phasing_chk #(
  parameter int NUM_OUTPUTS = 4,
  parameter int SEL_W = 2
) (
  // Clock and reset
  input logic i_core_clk,
  input logic i_rst,
  // Register bus
  input logic [phasing_pkg::ADDR_W-1:0] i_avs_address,
  input logic i_avs_read,
  input logic i_avs_write,
  input logic [31:0] i_avs_writedata,
  input logic [3:0] i_avs_byteenable,
  input logic [31:0] o_avs_readdata,
  input logic o_avs_waitrequest,
  // Phasing outputs
  input logic [NUM_OUTPUTS-1:0][phasing_pkg::TOTAL_W-1:0] o_payload_shift,
  input logic [NUM_OUTPUTS-1:0] o_shift_live,
  input logic [NUM_OUTPUTS-1:0] o_output_enable
);
  // Largest magnitude: 30 frames of 525 lines of 1716 clocks, less one
  localparam int SHIFT_LIM = 27026999;
  // Any request, and the write acceptance cycle
  wire req = i_avs_read | i_avs_write;
  wire ack = i_avs_write & ~o_avs_waitrequest;
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  //////////////////////////////////////////////////////////////////////////
  a_wait_once: assert property (req && o_avs_waitrequest |=> !o_avs_waitrequest)
    else $error("request not answered after one wait cycle");
  a_wait_idle: assert property (!req |-> !o_avs_waitrequest)
    else $error("waitrequest high with no request");
  // Reset guard: a one-edge reset may clear read data mid-hold
  a_read_stands: assert property (!$past(i_rst) && !$past(i_avs_read && o_avs_waitrequest)
    |-> $stable(o_avs_readdata))
    else $error("read data moved without a read capture");
  a_live_enabled: assert property ((o_shift_live & ~$past(o_output_enable)) == '0)
    else $error("live shift on a disabled output");
  a_live_single: assert property (!$past(i_rst)
    |-> $countones(o_shift_live ^ $past(o_shift_live)) <= 1)
    else $error("one access changed live on several outputs");
  a_enable_single: assert property (!$past(i_rst)
    |-> $countones(o_output_enable ^ $past(o_output_enable)) <= 1)
    else $error("one access changed several enables");
  a_shift_cause: assert property (($changed(o_payload_shift) || $changed(o_shift_live))
    |-> $past(ack, 2) || $past(i_rst) || $past(i_rst, 2))
    else $error("shift changed two cycles after no write");
  a_enable_cause: assert property ($changed(o_output_enable)
    |-> $past(ack && i_avs_address == phasing_pkg::REG_CTRL) || $past(i_rst))
    else $error("enable changed without a control write");
  for (genvar g = 0; g < NUM_OUTPUTS; g++) begin : g_out
    a_shift_range: assert property ($signed(o_payload_shift[g]) <= SHIFT_LIM
      && $signed(o_payload_shift[g]) >= -SHIFT_LIM)
      else $error("total shift outside the symmetric limit");
  end
  // Main scenarios reached
  c_write_ack: cover property (ack);
  c_live_on: cover property ($rose(o_shift_live[1]));
  c_neg_shift: cover property ($signed(o_payload_shift[1]) < 0);
endmodule
bind payload_phasing payload_phasing_chk #(.NUM_OUTPUTS(NUM_OUTPUTS), .SEL_W(SEL_W)) u_chk (
  .i_core_clk(i_core_clk), .i_rst(i_rst), .i_avs_address(i_avs_address),
  .i_avs_read(i_avs_read), .i_avs_write(i_avs_write), .i_avs_writedata(i_avs_writedata),
  .i_avs_byteenable(i_avs_byteenable), .o_avs_readdata(o_avs_readdata),
  .o_avs_waitrequest(o_avs_waitrequest), .o_payload_shift(o_payload_shift),
  .o_shift_live(o_shift_live), .o_output_enable(o_output_enable));

// file: dv/cfg_host_model.sv
// Host configuration model that drives the register bus
`timescale 1ns/1ps
module cfg_host_model (
  // Clock
  input logic i_core_clk,
  // Register bus towards the block
  output logic [phasing_pkg::ADDR_W-1:0] o_address,
  output logic o_read,
  output logic o_write,
  output logic [31:0] o_writedata,
  output logic [3:0] o_byteenable,
  input logic [31:0] i_readdata,
  input logic i_waitrequest,
  // Raised when an access is never answered
  output logic o_hang
);
  // Idle bus at time zero
  initial begin
    o_address = '0;
    o_read = 1'b0;
    o_write = 1'b0;
    o_writedata = '0;
    o_byteenable = '0;
    o_hang = 1'b0;
  end
  // One access; request held until a rising edge samples waitrequest low
  task automatic access(input logic wr, input logic [phasing_pkg::ADDR_W-1:0] addr,
                        input logic [31:0] data, output logic [31:0] rdata);
    logic busy;
    int n;
    @(posedge i_core_clk);
    o_address <= addr;
    o_read <= !wr;
    o_write <= wr;
    o_writedata <= data;
    o_byteenable <= phasing_pkg::FULL_BE;
    busy = 1'b1;
    n = 0;
    while (busy && n < 50) begin
      @(posedge i_core_clk);
      busy = i_waitrequest;
      rdata = i_readdata;
      n++;
    end
    if (busy) begin
      o_hang <= 1'b1;
    end
    o_read <= 1'b0;
    o_write <= 1'b0;
    // Released data lines show no stale value
    o_writedata <= ~data;
  endtask
  task automatic wr(input logic [phasing_pkg::ADDR_W-1:0] a, input logic [31:0] v);
    logic [31:0] d;
    access(1'b1, a, v, d);
  endtask
  task automatic rd(input logic [phasing_pkg::ADDR_W-1:0] a, output logic [31:0] v);
    access(1'b0, a, 32'h0, v);
  endtask
  // Select and enable the output, and choose the edited standard
  task automatic cfg(input logic [1:0] sel, input logic [1:0] std);
    wr(phasing_pkg::REG_CTRL, {22'h0, std, 3'h0, 1'b1, 2'h0, sel});
  endtask
endmodule

// file: dv/payload_phasing_tb_top.sv
// Self-checking bench for the payload phasing block
`timescale 1ns/1ps
`define CHK(got, exp, what) \
  begin \
    total_checks++; \
    if ((got) !== (exp)) begin \
      err_total++; \
      $display("unexpected %s: expected %h seen %h", what, exp, got); \
    end \
  end
module payload_phasing_tb_top;
  // Clock, reset and bus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [phasing_pkg::ADDR_W-1:0] address;
  logic read, write, waitreq, hang;
  logic [31:0] wdata, rdata;
  logic [3:0] be;
  // Block outputs
  logic [3:0][31:0] shift;
  logic [3:0] live, enable;
  int err_total = 0;
  int total_checks = 0;
  // Clocks per line and per frame, from the limits plus one
  localparam int NL = int'(phasing_pkg::NTSC_CLK_MAX) + 1;
  localparam int NF = NL * (int'(phasing_pkg::NTSC_LINE_MAX) + 1);
  localparam int PL = int'(phasing_pkg::PAL_B_CLK_MAX) + 1;
  int exp_line[3] = '{3, 1, 7};
  always #5 clk = ~clk;
  payload_phasing DUT (.i_core_clk(clk), .i_rst(rst), .i_avs_address(address),
    .i_avs_read(read), .i_avs_write(write), .i_avs_writedata(wdata),
    .i_avs_byteenable(be), .o_avs_readdata(rdata), .o_avs_waitrequest(waitreq),
    .o_payload_shift(shift), .o_shift_live(live), .o_output_enable(enable));
  cfg_host_model u_host (.i_core_clk(clk), .o_address(address), .o_read(read),
    .o_write(write), .o_writedata(wdata), .o_byteenable(be), .i_readdata(rdata),
    .i_waitrequest(waitreq), .o_hang(hang));
  //////////////////////////////////////////////////////////////////////////
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  // A hung access ends the run
  always @(posedge hang) begin
    err_total++;
    close_out();
  end
  task automatic chk_rd(input logic [4:0] a, input logic [31:0] e, input string what);
    logic [31:0] v;
    u_host.rd(a, v);
    `CHK(v, e, what)
  endtask
  // Total through the register and on the selected output's port
  task automatic chk_tot(input int o, input int e);
    logic [31:0] v;
    u_host.rd(phasing_pkg::REG_TOTAL, v);
    `CHK(v, 32'(e), "total")
    `CHK(shift[o], 32'(e), "shift port")
  endtask
  //////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    u_host.cfg(2'h1, 2'h0);
    u_host.wr(phasing_pkg::REG_FORMAT, 32'h0);
    chk_rd(phasing_pkg::REG_STATUS, 32'h50, "status");
    // Clock overflow ripples through the line into the frame
    u_host.wr(phasing_pkg::REG_CLK_OFF, 32'(phasing_pkg::NTSC_CLK_MAX));
    u_host.wr(phasing_pkg::REG_LINE_OFF, 32'(phasing_pkg::NTSC_LINE_MAX));
    u_host.wr(phasing_pkg::REG_ADJUST, 32'h00000001);
    chk_rd(phasing_pkg::REG_CLK_OFF, 32'h0, "clock");
    chk_rd(phasing_pkg::REG_LINE_OFF, 32'h0, "line");
    chk_rd(phasing_pkg::REG_FRAME_OFF, 32'h1, "frame");
    chk_tot(1, NF);
    // Underflow borrows upward through the chain
    u_host.wr(phasing_pkg::REG_CLK_OFF, 32'(-int'(phasing_pkg::NTSC_CLK_MAX)));
    u_host.wr(phasing_pkg::REG_LINE_OFF, 32'(-int'(phasing_pkg::NTSC_LINE_MAX)));
    u_host.wr(phasing_pkg::REG_FRAME_OFF, 32'h0);
    u_host.wr(phasing_pkg::REG_ADJUST, 32'h0000ffff);
    chk_rd(phasing_pkg::REG_LINE_OFF, 32'h0, "line");
    chk_rd(phasing_pkg::REG_FRAME_OFF, 32'hffffffff, "frame");
    chk_tot(1, -NF);
    // Frame wrap leaves the lower fields alone
    u_host.wr(phasing_pkg::REG_LINE_OFF, 32'h3);
    u_host.wr(phasing_pkg::REG_FRAME_OFF, 32'h1d);
    u_host.wr(phasing_pkg::REG_ADJUST, 32'h00020001);
    chk_rd(phasing_pkg::REG_FRAME_OFF, 32'h0, "frame");
    chk_rd(phasing_pkg::REG_LINE_OFF, 32'h3, "line");
    chk_tot(1, 3 * NL);
    // PAL-B entry edited apart from the active NTSC set, then recalled
    u_host.cfg(2'h1, 2'h1);
    u_host.wr(phasing_pkg::REG_CLK_OFF, 32'(phasing_pkg::PAL_B_CLK_MAX));
    u_host.wr(phasing_pkg::REG_ADJUST, 32'h00000001);
    chk_rd(phasing_pkg::REG_LINE_OFF, 32'h1, "line");
    chk_tot(1, 3 * NL);
    u_host.wr(phasing_pkg::REG_FORMAT, 32'h1);
    chk_tot(1, PL);
    u_host.wr(phasing_pkg::REG_FORMAT, 32'h0);
    chk_tot(1, 3 * NL);
    // PAL-M uses the NTSC limits
    u_host.cfg(2'h1, 2'h2);
    u_host.wr(phasing_pkg::REG_LINE_OFF, 32'h7);
    u_host.wr(phasing_pkg::REG_FORMAT, 32'h2);
    chk_tot(1, 7 * NL);
    // Each standard keeps its own entry, each output its own set
    for (int s = 0; s < 3; s++) begin
      u_host.cfg(2'h1, 2'(s));
      chk_rd(phasing_pkg::REG_LINE_OFF, 32'(exp_line[s]), "line per standard");
    end
    u_host.cfg(2'h2, 2'h0);
    chk_rd(phasing_pkg::REG_LINE_OFF, 32'h0, "other output line");
    chk_tot(2, 0);
    `CHK(live, 4'h6, "live")
    `CHK(enable, 4'h6, "enables")
    // High definition disables phasing and ignores offset writes
    u_host.cfg(2'h1, 2'h0);
    u_host.wr(phasing_pkg::REG_FORMAT, 32'h3);
    chk_tot(1, 0);
    `CHK(live[1], 1'b0, "live hd")
    u_host.wr(phasing_pkg::REG_LINE_OFF, 32'h9);
    chk_rd(phasing_pkg::REG_LINE_OFF, 32'h3, "line hd");
    chk_rd(phasing_pkg::REG_STATUS, 32'h33, "status hd");
    u_host.wr(phasing_pkg::REG_FORMAT, 32'h0);
    chk_tot(1, 3 * NL);
    // Write-only and unmapped places read as zero
    chk_rd(phasing_pkg::REG_ADJUST, 32'h0, "adjust read");
    chk_rd(5'h02, 32'h0, "unmapped read");
    close_out();
  end
endmodule
